// *** common/dscr_defines.svh ***
// Register offsets, field positions, reset values and keys of the shared control registers
`ifndef DSCR_DEFINES_SVH
`define DSCR_DEFINES_SVH

`define DSCR_NUM_CH 2
`define DSCR_ADDR_CODE0 8'h1C
`define DSCR_ADDR_CODE1 8'h19
`define DSCR_ADDR_CFG 8'h1F
`define DSCR_ADDR_TRIG 8'h20

`define DSCR_CFG_RST 16'h0FFF
`define DSCR_CODE_RST 16'h0000
`define DSCR_CODE_MID 16'h8000
`define DSCR_CFG_WLATCH 15
`define DSCR_CFG_LOCK 14
`define DSCR_CFG_ROWSEL 13
`define DSCR_CFG_INTREF 12
`define DSCR_CFG_VPD0_HI 11
`define DSCR_CFG_VPD0_LO 10
`define DSCR_CFG_IPD0 9
`define DSCR_CFG_RSVD_HI 8
`define DSCR_CFG_RSVD_LO 3
`define DSCR_CFG_RSVD_VAL 6'h3F
`define DSCR_CFG_VPD1_HI 2
`define DSCR_CFG_VPD1_LO 1
`define DSCR_CFG_IPD1 0

`define DSCR_TRIG_PW_HI 15
`define DSCR_TRIG_PW_LO 12
`define DSCR_TRIG_POR_HI 11
`define DSCR_TRIG_POR_LO 8
`define DSCR_TRIG_LOAD 7
`define DSCR_TRIG_CLR 6
`define DSCR_TRIG_DUMP 4
`define DSCR_TRIG_PROT 3
`define DSCR_TRIG_ROW 2
`define DSCR_TRIG_NVW 1
`define DSCR_TRIG_NVR 0
`define DSCR_PASSWORD 4'h5
`define DSCR_POR_KEY 4'hA

`endif

// *** common/dscr_pkg.sv ***
// Types shared by the shared control register block
package dscr_pkg;

   typedef enum logic [1:0] {
      DSCR_VPD_UP = 2'b00,
      DSCR_VPD_10K = 2'b01,
      DSCR_VPD_100K = 2'b10,
      DSCR_VPD_HIZ = 2'b11
   } dscr_vpd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } dscr_req_t;

   typedef struct packed {
      logic sync_load;
      logic clear;
      logic fault_dump;
      logic protect;
      logic row_read;
      logic nv_write;
      logic nv_reload;
   } dscr_action_t;

   typedef struct packed {
      logic window_latch_select;
      logic register_lock_bit;
      logic dump_row_select;
      logic int_ref_enable;
      dscr_vpd_t [1:0] voltage_out_powerdown;
      logic [1:0] current_out_powerdown;
   } dscr_cfg_t;

   typedef struct packed {
      logic [15:0] cfg;
      logic [1:0][15:0] code;
   } dscr_nv_image_t;

endpackage : dscr_pkg

// *** hw/dscr_chan.sv ***
// One channel: output code register and the code that drives the converter
`timescale 1ns/10ps
`include "dscr_defines.svh"
module dscr_chan #(
   parameter int CODE_BITS = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_por,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   input wire logic sync_sel,
   input wire logic load_pulse,
   input wire logic clr_pulse,
   input wire logic clr_mid,
   input wire logic nv_load,
   input wire logic [15:0] nv_code,
   output logic [15:0] code_rd,
   output logic [15:0] out_code
);
   localparam int PAD = 16 - CODE_BITS;
   logic [CODE_BITS-1:0] code_ff;
   logic [CODE_BITS-1:0] nxt_code;
   logic [CODE_BITS-1:0] out_ff;
   logic [CODE_BITS-1:0] nxt_out;
   logic [15:0] clr_val;

   assign clr_val = clr_mid ? `DSCR_CODE_MID : `DSCR_CODE_RST;

   always_comb begin
      nxt_code = code_ff;
      nxt_out = out_ff;
      if (soft_por) begin
         nxt_code = '0;
         nxt_out = '0;
      end else if (clr_pulse) begin
         nxt_code = clr_val[15 -: CODE_BITS];
         nxt_out = clr_val[15 -: CODE_BITS];
      end else if (nv_load) begin
         nxt_code = nv_code[15 -: CODE_BITS];
         nxt_out = nv_code[15 -: CODE_BITS];
      end else if (wr_en) begin
         // Low bits below the code width are dropped
         nxt_code = wdata[15 -: CODE_BITS];
         if (!sync_sel) begin
            nxt_out = wdata[15 -: CODE_BITS];
         end
      end else if (load_pulse && sync_sel) begin
         nxt_out = code_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_ff <= '0;
         out_ff <= '0;
      end else begin
         code_ff <= nxt_code;
         out_ff <= nxt_out;
      end
   end

   assign code_rd = {code_ff, {PAD{1'b0}}};
   assign out_code = {out_ff, {PAD{1'b0}}};

endmodule : dscr_chan

// *** hw/dscr_trig.sv ***
// Shared action register: password, reset key and self-clearing commands
`timescale 1ns/10ps
`include "dscr_defines.svh"
module dscr_trig (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_por,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   input wire logic locked,
   input wire logic unlock_now,
   output dscr_pkg::dscr_action_t act,
   output logic por_pulse,
   output logic pw_ok,
   output logic [15:0] rdata
);
   logic [3:0] pw_ff;
   logic [3:0] nxt_pw;
   dscr_pkg::dscr_action_t act_ff;
   dscr_pkg::dscr_action_t nxt_act;
   logic por_ff;
   logic nxt_por;
   logic wr_open;

   assign wr_open = wr_en && !locked;
   assign nxt_pw = soft_por ? 4'h0 : unlock_now ? 4'h0 : wr_en ? wdata[`DSCR_TRIG_PW_HI:`DSCR_TRIG_PW_LO] : pw_ff;
   assign nxt_por = wr_open && (wdata[`DSCR_TRIG_POR_HI:`DSCR_TRIG_POR_LO] == `DSCR_POR_KEY);

   // Each command bit lives exactly one cycle, which is its launch pulse
   always_comb begin
      nxt_act = '0;
      if (wr_open && !soft_por) begin
         nxt_act.sync_load = wdata[`DSCR_TRIG_LOAD];
         nxt_act.clear = wdata[`DSCR_TRIG_CLR];
         nxt_act.fault_dump = wdata[`DSCR_TRIG_DUMP];
         nxt_act.protect = wdata[`DSCR_TRIG_PROT];
         nxt_act.row_read = wdata[`DSCR_TRIG_ROW];
         nxt_act.nv_write = wdata[`DSCR_TRIG_NVW];
         nxt_act.nv_reload = wdata[`DSCR_TRIG_NVR];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pw_ff <= 4'h0;
         act_ff <= '0;
         por_ff <= 1'b0;
      end else begin
         pw_ff <= nxt_pw;
         act_ff <= nxt_act;
         por_ff <= nxt_por;
      end
   end

   assign act = act_ff;
   assign por_pulse = por_ff;
   assign pw_ok = (pw_ff == `DSCR_PASSWORD);
   // Reset key field always reads zero
   assign rdata = {pw_ff, 4'h0, act_ff.sync_load, act_ff.clear, 1'b0, act_ff.fault_dump,
                   act_ff.protect, act_ff.row_read, act_ff.nv_write, act_ff.nv_reload};

endmodule : dscr_trig

// *** hw/dscr_top.sv ***
// Shared control registers of a dual-channel converter: codes, configuration and actions
//
// Overview of operation
// - Channel code is unsigned binary, MSB at bit 15; unused low bits ignored.
// - Configuration bit 15 selects non-latching or latching window comparator output.
// - Lock bit 14 set blocks host writes to every register except the action password field and the unlock write.
// - Unlock needs password 0101 in action bits 15-12, then lock written zero.
// - Configuration bit 13 picks fault-dump row 0x00 or 0x01.
// - Voltage power-down fields 00 up to 11 high-Z; current bits 1 down.
// - Writing 1010 to action bits 11-8 fires a full reset; field reads zero.
// - Action bit 7 loads each channel with sync select set, then clears.
// - Action bit 6 forces codes to zero or mid per channel, then clears.
// - Action bit 4 starts the fault-dump sequence and clears itself.
// - Action bit 3 invokes the protect function and clears itself.
// - Action bit 2 reads one nonvolatile row for fault dump, then clears.
// - Action bit 1 starts nonvolatile programming and clears itself.
// - Action bit 0 reloads stored nonvolatile contents into registers, then clears.
// - Configuration resets to 0x0FFF; bits 8-3 read back their reset pattern.
`timescale 1ns/10ps
`include "dscr_defines.svh"
module dscr_top #(
   parameter int CODE_BITS = 12
) (
   input wire logic clk,
   input wire logic resetn,
   input dscr_pkg::dscr_req_t req,
   input wire logic [1:0] sync_load_select,
   input wire logic [1:0] clear_level_select,
   input wire logic nv_load_valid,
   input dscr_pkg::dscr_nv_image_t nv_image,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output dscr_pkg::dscr_cfg_t cfg,
   output logic [1:0][15:0] out_code,
   output dscr_pkg::dscr_action_t action,
   output logic soft_por
);
   // Reset release through two flip-flops
   logic rst_s1_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n <= rst_s1_ff;
      end
   end

   // Address decode
   wire sel_cfg = (req.addr == `DSCR_ADDR_CFG);
   wire sel_trig = (req.addr == `DSCR_ADDR_TRIG);
   wire sel_code0 = (req.addr == `DSCR_ADDR_CODE0);
   wire sel_code1 = (req.addr == `DSCR_ADDR_CODE1);
   wire [1:0] sel_code = {sel_code1, sel_code0};
   wire wr_cfg = req.wr && sel_cfg;
   wire wr_trig = req.wr && sel_trig;

   logic [15:0] cfg_ff;
   logic [15:0] nxt_cfg;
   logic por_pulse;
   logic pw_ok;
   logic [15:0] trig_rd;
   dscr_pkg::dscr_action_t act;
   logic [1:0][15:0] code_rd;
   logic [1:0][15:0] code_out;

   wire locked = cfg_ff[`DSCR_CFG_LOCK];
   wire unlock_now = wr_cfg && locked && pw_ok && !req.wdata[`DSCR_CFG_LOCK];
   wire [15:0] cfg_wr_val = {req.wdata[15:`DSCR_CFG_RSVD_HI+1], `DSCR_CFG_RSVD_VAL,
                             req.wdata[`DSCR_CFG_RSVD_LO-1:0]};

   // Configuration register; reload from storage overrides a host write in the same cycle
   always_comb begin
      nxt_cfg = cfg_ff;
      if (por_pulse) begin
         nxt_cfg = `DSCR_CFG_RST;
      end else if (nv_load_valid) begin
         nxt_cfg = {nv_image.cfg[15:`DSCR_CFG_RSVD_HI+1], `DSCR_CFG_RSVD_VAL,
                    nv_image.cfg[`DSCR_CFG_RSVD_LO-1:0]};
      end else if (wr_cfg && !locked) begin
         nxt_cfg = cfg_wr_val;
      end else if (unlock_now) begin
         // Only the lock bit moves; a locked write with lock still set changes nothing
         nxt_cfg[`DSCR_CFG_LOCK] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `DSCR_CFG_RST;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Field view of the configuration
   assign cfg.window_latch_select = cfg_ff[`DSCR_CFG_WLATCH];
   assign cfg.register_lock_bit = cfg_ff[`DSCR_CFG_LOCK];
   assign cfg.dump_row_select = cfg_ff[`DSCR_CFG_ROWSEL];
   assign cfg.int_ref_enable = cfg_ff[`DSCR_CFG_INTREF];
   assign cfg.voltage_out_powerdown[0] = dscr_pkg::dscr_vpd_t'(cfg_ff[`DSCR_CFG_VPD0_HI:`DSCR_CFG_VPD0_LO]);
   assign cfg.voltage_out_powerdown[1] = dscr_pkg::dscr_vpd_t'(cfg_ff[`DSCR_CFG_VPD1_HI:`DSCR_CFG_VPD1_LO]);
   assign cfg.current_out_powerdown = {cfg_ff[`DSCR_CFG_IPD1], cfg_ff[`DSCR_CFG_IPD0]};

   dscr_trig u_trig (
      .clk(clk),
      .rst_n(rst_n),
      .soft_por(por_pulse),
      .wr_en(wr_trig),
      .wdata(req.wdata),
      .locked(locked),
      .unlock_now(unlock_now),
      .act(act),
      .por_pulse(por_pulse),
      .pw_ok(pw_ok),
      .rdata(trig_rd)
   );

   assign action = act;
   assign soft_por = por_pulse;

   genvar ch;
   generate
      for (ch = 0; ch < `DSCR_NUM_CH; ch++) begin : g_ch
         dscr_chan #(
            .CODE_BITS(CODE_BITS)
         ) u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .soft_por(por_pulse),
            .wr_en(req.wr && sel_code[ch] && !locked),
            .wdata(req.wdata),
            .sync_sel(sync_load_select[ch]),
            .load_pulse(act.sync_load),
            .clr_pulse(act.clear),
            .clr_mid(clear_level_select[ch]),
            .nv_load(nv_load_valid),
            .nv_code(nv_image.code[ch]),
            .code_rd(code_rd[ch]),
            .out_code(code_out[ch])
         );
      end
   endgenerate

   assign out_code = code_out;

   // Read data is registered; unmapped offsets read zero
   wire [15:0] rd_mux = sel_cfg ? cfg_ff :
                        sel_trig ? trig_rd :
                        sel_code0 ? code_rd[0] :
                        sel_code1 ? code_rd[1] : 16'h0000;
   logic [15:0] rdata_ff;
   logic rvalid_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= req.rd ? rd_mux : rdata_ff;
         rvalid_ff <= req.rd;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;

endmodule : dscr_top

// *** testbench/dscr_top_monitor.sv ***
// Assertion checker for the shared control register block
`timescale 1ns/10ps
module dscr_top_monitor #(
   parameter int CODE_BITS = 12
) (
   input wire logic clk,
   input wire logic resetn,
   input dscr_pkg::dscr_req_t req,
   input wire logic [1:0] clear_level_select,
   input wire logic nv_load_valid,
   input dscr_pkg::dscr_nv_image_t nv_image,
   input dscr_pkg::dscr_cfg_t cfg,
   input wire logic [1:0][15:0] out_code,
   input dscr_pkg::dscr_action_t action,
   input wire logic soft_por
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire logic locked = cfg.register_lock_bit;
   wire logic wtrig = req.wr && req.addr == 8'h20 && !locked;
   wire logic wcfg = req.wr && req.addr == 8'h1F && !locked;
   AST_CODE_LSB: assert property (out_code[0][15-CODE_BITS:0] == '0) else $error("code low bits set");
   AST_LOAD: assert property (wtrig && req.wdata[7] |=> action.sync_load) else $error("no load pulse");
   AST_PULSE: assert property (action.clear |=> !action.clear) else $error("clear pulse too long");
   AST_CLEAR: assert property (action.clear && !soft_por |=>
      out_code[0] == ($past(clear_level_select[0]) ? 16'h8000 : 16'h0000)) else $error("clear level wrong");
   AST_LOCKED: assert property (locked && req.wr && req.addr == 8'h20 |=> action == '0) else $error("locked act");
   AST_POR: assert property (wtrig && req.wdata[11:8] == 4'hA |=> soft_por) else $error("no soft reset");
   AST_NOPOR: assert property (req.wr && req.addr == 8'h20 && req.wdata[11:8] != 4'hA |=> !soft_por)
      else $error("stray soft reset");
   AST_PORVAL: assert property (soft_por |=> cfg == 10'h03F && out_code == '0) else $error("not reset");
   AST_NV: assert property (nv_load_valid && !soft_por |=> cfg.dump_row_select == $past(nv_image.cfg[13])
      && cfg.window_latch_select == $past(nv_image.cfg[15])) else $error("reload not applied");
   AST_CFGW: assert property (wcfg && !nv_load_valid && !soft_por |=>
      cfg.voltage_out_powerdown[0] == $past(req.wdata[11:10]) && cfg.dump_row_select == $past(req.wdata[13])
      && cfg.window_latch_select == $past(req.wdata[15])) else $error("config write lost");
endmodule : dscr_top_monitor
bind dscr_top dscr_top_monitor #(.CODE_BITS(CODE_BITS)) u_mon (.clk, .resetn, .req, .clear_level_select,
   .nv_load_valid, .nv_image, .cfg, .out_code, .action, .soft_por);

// *** testbench/dscr_nv_model.sv ***
// Storage engine model: answers a reload request with a stored register image
`timescale 1ns/10ps
module dscr_nv_model #(
   parameter int DELAY = 3,
   parameter logic [47:0] IMAGE = 48'h0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic nv_reload,
   output logic nv_load_valid,
   output dscr_pkg::dscr_nv_image_t nv_image
);
   int cnt_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cnt_ff <= 0;
      else if (nv_reload)
         cnt_ff <= DELAY;
      else if (cnt_ff > 0)
         cnt_ff <= cnt_ff - 1;
   end
   assign nv_load_valid = (cnt_ff == 1);
   // Scrambled outside the pulse so the block cannot lean on stale data
   assign nv_image = nv_load_valid ? IMAGE : ~IMAGE;
endmodule : dscr_nv_model

// *** testbench/dac_shared_control_regs_tb.sv ***
// Testbench of the shared control register block
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: %h not %h", $time, (a), (e)); end end
module dac_shared_control_regs_tb;
   logic clk, resetn, nv_load_valid, reg_rvalid, soft_por, por_seen;
   logic [1:0] sync_sel, clr_sel;
   logic [15:0] reg_rdata;
   logic [1:0][15:0] out_code;
   dscr_pkg::dscr_req_t req;
   dscr_pkg::dscr_nv_image_t nv_image;
   dscr_pkg::dscr_cfg_t cfg;
   dscr_pkg::dscr_action_t action, act_seen;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   dscr_top #(.CODE_BITS(12)) u_dut (.clk, .resetn, .req, .sync_load_select(sync_sel), .clear_level_select(clr_sel),
      .nv_load_valid, .nv_image, .reg_rdata, .reg_rvalid, .cfg, .out_code, .action, .soft_por);
   dscr_nv_model #(.IMAGE(48'hA000_1230_ABC0)) u_nv (.clk, .resetn, .nv_reload(action.nv_reload),
      .nv_load_valid, .nv_image);
   task automatic end_sim();
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      #1 act_seen = action;
      por_seen = soft_por;
      @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 `CHK(reg_rvalid ? reg_rdata : 16'hXXXX, e)
   endtask : rd
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      resetn = 1'b0;
      req = '0;
      sync_sel = 2'b00;
      clr_sel = 2'b01;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h1F, 16'h0FFF);
      `CHK(cfg, 10'h03F)
      rd(8'h20, 16'h0000);
      rd(8'h21, 16'h0000);
      wr(8'h1C, 16'hABCF);
      rd(8'h1C, 16'hABC0);
      `CHK(out_code[0], 16'hABC0)
      wr(8'h19, 16'h777F);
      rd(8'h19, 16'h7770);
      `CHK(out_code[1], 16'h7770)
      wr(8'h1F, 16'hB405);
      rd(8'h1F, 16'hB5FD);
      `CHK(cfg, 10'h2E6)
      sync_sel <= 2'b01;
      wr(8'h1C, 16'h5550);
      `CHK(out_code[0], 16'hABC0)
      wr(8'h20, 16'h0080);
      `CHK(act_seen.sync_load, 1'b1)
      `CHK(out_code[0], 16'h5550)
      rd(8'h20, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         wr(8'h20, 16'h0001 << i);
         `CHK(act_seen, 7'(1 << i))
      end
      rd(8'h1F, 16'hA1F8);
      `CHK(out_code[1], 16'h1230)
      wr(8'h20, 16'h0040);
      `CHK(out_code, {16'h0000, 16'h8000})
      rd(8'h1C, 16'h8000);
      wr(8'h1F, 16'h4FFF);
      wr(8'h1C, 16'h1110);
      rd(8'h1C, 16'h8000);
      wr(8'h19, 16'h2220);
      rd(8'h19, 16'h0000);
      wr(8'h20, 16'h3040);
      `CHK(act_seen, 7'h00)
      wr(8'h1F, 16'h0FFF);
      rd(8'h1F, 16'h4FFF);
      wr(8'h20, 16'h5000);
      wr(8'h1F, 16'h0FFF);
      rd(8'h1F, 16'h0FFF);
      wr(8'h20, 16'h0B00);
      `CHK(por_seen, 1'b0)
      wr(8'h1F, 16'h8FFF);
      wr(8'h20, 16'h0A00);
      `CHK(por_seen, 1'b1)
      rd(8'h1F, 16'h0FFF);
      `CHK(out_code, 32'h0)
      end_sim();
   end
endmodule : dac_shared_control_regs_tb
